// *** inc/sssio_consts.vh ***
// Constants of the clocked serial shift unit: register map, fields, reset values, vectors, responses.
// Included by the top design file only; holds definitions only.
`ifndef SSSIO_CONSTS_VH
`define SSSIO_CONSTS_VH

// Register byte offsets
`define SSSIO_MODE_OFS 4'h0
`define SSSIO_DATA_OFS 4'h4
`define SSSIO_LEVEL_OFS 4'h8
`define SSSIO_STAT_OFS 4'hC

// Mode control register fields
`define SSSIO_F_DONE 7
`define SSSIO_F_IRQEN 6
`define SSSIO_F_CKOE 5
`define SSSIO_F_DOE 4
`define SSSIO_F_CKS_HI 3
`define SSSIO_F_CKS_LO 2
`define SSSIO_F_ORDER 1
`define SSSIO_F_GO 0

// Level register fields
`define SSSIO_F_LVL_HI 3
`define SSSIO_F_LVL_LO 2

// Status register fields
`define SSSIO_F_STOPPED 4

// Reset values
`define SSSIO_MODE_RST 8'h00
`define SSSIO_DATA_RST 8'h00
`define SSSIO_LEVEL_RST 8'hFF

// Clock source code for the external shift clock
`define SSSIO_CKS_EXT 2'h3

// Vector addresses
`define SSSIO_VEC_HI 16'hFFF0
`define SSSIO_VEC_LO 16'hFFF1

// Bits per byte transfer
`define SSSIO_BITS 4'h8

// AXI responses
`define SSSIO_RESP_OKAY 2'h0
`define SSSIO_RESP_SLVERR 2'h2

`endif

// *** design/sssio_sync.v ***
// Two-flip-flop synchroniser for one level from outside the aclk domain.
// Assumes aclk is free running; first stage feeds only the second.
`timescale 1ns/100ps
`default_nettype none

module sssio_sync #(
    parameter RST_VAL = 1'b0
) (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire d_in,
    output reg q_out
);
    reg meta_r;

    always @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= RST_VAL;
            q_out <= RST_VAL;
        end else if (ce) begin
            meta_r <= d_in;
            q_out <= meta_r;
        end
    end
endmodule

`default_nettype wire

// *** design/sssio_clkgen.v ***
// Internal shift clock generator: three selectable rates.
// Assumes run is a level on aclk; output idles high when not running.
`timescale 1ns/100ps
`default_nettype none

module sssio_clkgen #(
    parameter DIV0 = 16,
    parameter DIV1 = 64,
    parameter DIV2 = 256,
    parameter CW = 9
) (
    input wire aclk,
    input wire aresetn,
    input wire ce,
    input wire run,
    input wire [1:0] sel,
    output reg sck_out,
    output reg fall_pulse,
    output reg rise_pulse
);
    reg [CW-1:0] cnt_r;
    reg [CW-1:0] half;

    always @* begin
        case (sel)
            2'h0: half = DIV0[CW-1:0];
            2'h1: half = DIV1[CW-1:0];
            default: half = DIV2[CW-1:0];
        endcase
    end

    // Idle high so that the first edge seen by the partner is falling
    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= {CW{1'b0}};
            sck_out <= 1'b1;
            fall_pulse <= 1'b0;
            rise_pulse <= 1'b0;
        end else if (ce) begin
            fall_pulse <= 1'b0;
            rise_pulse <= 1'b0;
            if (!run) begin
                cnt_r <= {CW{1'b0}};
                sck_out <= 1'b1;
            end else if (cnt_r >= half - {{(CW-1){1'b0}}, 1'b1}) begin
                cnt_r <= {CW{1'b0}};
                sck_out <= ~sck_out;
                fall_pulse <= sck_out;
                rise_pulse <= ~sck_out;
            end else begin
                cnt_r <= cnt_r + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

`default_nettype wire

// *** design/sssio_top.v ***
// Clocked serial shift unit: 8-bit full-duplex shifter behind AXI4-Lite.
// Assumes shift clock and serial input pins are asynchronous to aclk.
`timescale 1ns/100ps
`default_nettype none
`include "sssio_consts.vh"

module sssio_top #(
    parameter DIV0 = 16,
    parameter DIV1 = 64,
    parameter DIV2 = 256
) (
    input wire aclk,
    input wire aresetn,
    input wire clk_en,
    input wire sleep_mode,
    input wire stop_mode,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire sck_in,
    output reg sck_out,
    output reg sck_oe,
    input wire sdi_in,
    output reg sdo_out,
    output reg sdo_oe,
    output reg serial_irq_line,
    output reg [1:0] irq_level
);
    // Mode control register bits, then the data, level and bit count registers
    reg xfer_done_flag_r;
    reg xfer_irq_enable_r;
    reg clk_out_enable_r;
    reg data_out_enable_r;
    reg [1:0] clk_source_sel_r;
    reg bit_order_sel_r;
    reg transfer_go_r;
    reg [7:0] shift_data_r;
    reg [7:0] irq_level_reg2_r;
    reg [3:0] bit_cnt_r;

    wire ext_sel = (clk_source_sel_r == `SSSIO_CKS_EXT);
    wire sck_sync;
    wire sdi_sync;
    reg sck_prev_r;
    wire int_sck;
    wire int_fall;
    wire int_rise;

    // Stop mode freezes the clock generator and all shift edges; synchronisers and bus keep running
    wire run_ce = clk_en & ~stop_mode;

    sssio_sync #(.RST_VAL(1'b1)) u_sync_sck (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(clk_en),
        .d_in(sck_in),
        .q_out(sck_sync)
    );

    sssio_sync #(.RST_VAL(1'b0)) u_sync_sdi (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(clk_en),
        .d_in(sdi_in),
        .q_out(sdi_sync)
    );

    sssio_clkgen #(.DIV0(DIV0), .DIV1(DIV1), .DIV2(DIV2), .CW(9)) u_clkgen (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(run_ce),
        .run(transfer_go_r & ~ext_sel),
        .sel(clk_source_sel_r),
        .sck_out(int_sck),
        .fall_pulse(int_fall),
        .rise_pulse(int_rise)
    );

    always @(posedge aclk) begin
        if (!aresetn) begin
            sck_prev_r <= 1'b1;
        end else if (clk_en) begin
            sck_prev_r <= sck_sync;
        end
    end

    // External edges are dropped in stop, so a resumed byte is out of step
    wire ext_fall = ext_sel & sck_prev_r & ~sck_sync & ~stop_mode;
    wire ext_rise = ext_sel & ~sck_prev_r & sck_sync & ~stop_mode;
    wire sh_fall = ext_sel ? ext_fall : (int_fall & run_ce);
    wire sh_rise = ext_sel ? ext_rise : (int_rise & run_ce);

    // Bus handshake state
    reg [3:0] aw_addr_r;
    reg aw_held_r;
    reg [31:0] w_data_r;
    reg [3:0] w_strb_r;
    reg w_held_r;

    wire wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;
    wire wr_mode = wr_fire & (aw_addr_r == `SSSIO_MODE_OFS) & w_strb_r[0];
    wire wr_data = wr_fire & (aw_addr_r == `SSSIO_DATA_OFS) & w_strb_r[0];
    wire wr_level = wr_fire & (aw_addr_r == `SSSIO_LEVEL_OFS) & w_strb_r[0];
    wire wr_ok = (aw_addr_r == `SSSIO_MODE_OFS) | (aw_addr_r == `SSSIO_DATA_OFS)
        | (aw_addr_r == `SSSIO_LEVEL_OFS) | (aw_addr_r == `SSSIO_STAT_OFS);
    wire go_write1 = wr_mode & w_data_r[`SSSIO_F_GO];
    wire go_write0 = wr_mode & ~w_data_r[`SSSIO_F_GO];

    // Eighth rising edge completes the byte
    wire last_rise = transfer_go_r & sh_rise & (bit_cnt_r == `SSSIO_BITS - 4'h1);
    wire done_set = last_rise & ~go_write0;
    wire out_bit = bit_order_sel_r ? shift_data_r[7] : shift_data_r[0];

    always @(posedge aclk) begin
        if (!aresetn) begin
            xfer_done_flag_r <= 1'b0;
            xfer_irq_enable_r <= 1'b0;
            clk_out_enable_r <= 1'b0;
            data_out_enable_r <= 1'b0;
            clk_source_sel_r <= 2'h0;
            bit_order_sel_r <= 1'b0;
            transfer_go_r <= 1'b0;
            shift_data_r <= `SSSIO_DATA_RST;
            irq_level_reg2_r <= `SSSIO_LEVEL_RST;
            bit_cnt_r <= 4'h0;
        end else if (clk_en) begin
            if (wr_mode) begin
                xfer_irq_enable_r <= w_data_r[`SSSIO_F_IRQEN];
                clk_out_enable_r <= w_data_r[`SSSIO_F_CKOE];
                data_out_enable_r <= w_data_r[`SSSIO_F_DOE];
                clk_source_sel_r <= w_data_r[`SSSIO_F_CKS_HI:`SSSIO_F_CKS_LO];
                bit_order_sel_r <= w_data_r[`SSSIO_F_ORDER];
            end
            if (wr_level) begin
                irq_level_reg2_r <= w_data_r[7:0];
            end
            // Set wins over a software clear in the same cycle only if that write keeps GO set
            if (done_set) begin
                xfer_done_flag_r <= 1'b1;
            end else if (wr_mode && !w_data_r[`SSSIO_F_DONE]) begin
                xfer_done_flag_r <= 1'b0;
            end
            if (go_write1) begin
                transfer_go_r <= 1'b1;
                bit_cnt_r <= 4'h0;
            end else if (go_write0) begin
                transfer_go_r <= 1'b0;
                bit_cnt_r <= 4'h0;
            end else if (last_rise) begin
                transfer_go_r <= 1'b0;
                bit_cnt_r <= 4'h0;
            end else if (transfer_go_r && sh_rise) begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end
            // Shift in one bit per rising edge while running
            if (wr_data) begin
                shift_data_r <= w_data_r[7:0];
            end else if (transfer_go_r && sh_rise) begin
                if (bit_order_sel_r) begin
                    shift_data_r <= {shift_data_r[6:0], sdi_sync};
                end else begin
                    shift_data_r <= {sdi_sync, shift_data_r[7:1]};
                end
            end
        end
    end

    // Pin drivers
    always @(posedge aclk) begin
        if (!aresetn) begin
            sck_out <= 1'b1;
            sck_oe <= 1'b0;
            sdo_out <= 1'b1;
            sdo_oe <= 1'b0;
            serial_irq_line <= 1'b0;
            irq_level <= 2'h3;
        end else if (clk_en) begin
            sck_out <= ext_sel ? 1'b1 : int_sck;
            sck_oe <= clk_out_enable_r & ~ext_sel;
            sdo_oe <= data_out_enable_r;
            // Halted external clock still moves the output pin
            if (sh_fall && (transfer_go_r || ext_sel)) begin
                sdo_out <= out_bit;
            end
            serial_irq_line <= xfer_done_flag_r & xfer_irq_enable_r;
            irq_level <= irq_level_reg2_r[`SSSIO_F_LVL_HI:`SSSIO_F_LVL_LO];
        end
    end

    // AXI4-Lite write channel: address and data accepted in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `SSSIO_RESP_OKAY;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 4'h0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end else if (clk_en) begin
            s_axi_awready <= ~aw_held_r & ~s_axi_awready & s_axi_awvalid;
            s_axi_wready <= ~w_held_r & ~s_axi_wready & s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_r <= 1'b1;
                aw_addr_r <= {s_axi_awaddr[3:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `SSSIO_RESP_OKAY : `SSSIO_RESP_SLVERR;
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel
    reg [31:0] rd_mux;
    reg rd_ok;
    always @* begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b1;
        case ({s_axi_araddr[3:2], 2'b00})
            `SSSIO_MODE_OFS: rd_mux = {24'h000000, xfer_done_flag_r, xfer_irq_enable_r,
                clk_out_enable_r, data_out_enable_r, clk_source_sel_r,
                bit_order_sel_r, transfer_go_r};
            `SSSIO_DATA_OFS: rd_mux = {24'h000000, shift_data_r};
            `SSSIO_LEVEL_OFS: rd_mux = {24'h000000, irq_level_reg2_r};
            `SSSIO_STAT_OFS: rd_mux = {27'h0000000, stop_mode, bit_cnt_r};
            default: rd_ok = 1'b0;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `SSSIO_RESP_OKAY;
        end else if (clk_en) begin
            s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= rd_ok ? `SSSIO_RESP_OKAY : `SSSIO_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule

`default_nettype wire

// *** tb/sssio_chk_sva.sv ***
// Port checker for the serial shift unit, bound into its top module.
// Assumes clk_en stays high while the bus is in use.
`timescale 1ns/100ps
`default_nettype none
module sssio_chk #(
    parameter int DIV2 = 256
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic stop_mode,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic sck_out,
    input wire logic sdo_out,
    input wire logic serial_irq_line
);
    // Slowest half period plus slack for the output register
    localparam int HMAX = DIV2 + 4;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    AST_RST_IDLE: assert property ($rose(aresetn) |-> sck_out && sdo_out && !serial_irq_line)
        else $error("outputs not idle after reset");
    AST_CE_FREEZE: assert property (!clk_en |=> $stable(sck_out) && $stable(sdo_out)
        && $stable(serial_irq_line)) else $error("outputs moved with clock enable low");
    AST_STOP_HOLD: assert property (stop_mode && clk_en |=> $stable(sck_out) && $stable(sdo_out))
        else $error("shift pins moved in stop mode");
    AST_SCK_HIGH: assert property ($fell(sck_out) |-> ##[1:HMAX] (sck_out || stop_mode || !clk_en))
        else $error("driven shift clock stuck low");
    AST_AW_TAKE: assert property ($rose(s_axi_awvalid) && clk_en |=> s_axi_awready)
        else $error("write address not taken");
    AST_W_TAKE: assert property ($rose(s_axi_wvalid) && clk_en |=> s_axi_wready)
        else $error("write data not taken");
    AST_B_AFTER: assert property (s_axi_awready && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write response late");
    AST_R_AFTER: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
endmodule
bind sssio_top sssio_chk #(.DIV2(DIV2)) i_sssio_chk (.*);
`default_nettype wire

// *** tb/sssio_peer.sv ***
// Far-side serial partner: follows a driven clock or makes its own.
// Assumes the bench loads it before each byte.
`timescale 1ns/100ps
`default_nettype none
module sssio_peer (
    input wire logic sck_out,
    input wire logic sck_oe,
    input wire logic sdo_out,
    output logic sck_in,
    output logic sdi_in
);
    logic [7:0] tx = 8'h00;
    logic [7:0] rx = 8'h00;
    logic msb = 1'b0;
    logic sck_r = 1'b1;
    int n = 0;
    assign sck_in = sck_r;
    initial sdi_in = 1'b0;
    task automatic load(input logic [7:0] t, input logic m);
        tx = t;
        msb = m;
        n = 0;
    endtask
    task automatic put_bit;
        if (n < 8) sdi_in = msb ? tx[7 - n] : tx[n];
    endtask
    task automatic take_bit;
        rx = msb ? {rx[6:0], sdo_out} : {sdo_out, rx[7:1]};
        n++;
        // Released line must not keep the last bit
        if (n == 8) sdi_in = ~sdi_in;
    endtask
    always @(negedge sck_out) if (sck_oe === 1'b1) put_bit();
    always @(posedge sck_out) if (sck_oe === 1'b1) take_bit();
    // Odd start offset keeps pin changes off the bench clock edge
    task automatic frame(input int bits);
        #7;
        repeat (bits) begin
            sck_r = 1'b0;
            put_bit();
            #160;
            sck_r = 1'b1;
            #160;
            take_bit();
        end
    endtask
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the serial shift unit and its partner.
// Assumes the partner model and the bound checker are compiled too.
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1, sleep_mode = 1'b0, stop_mode = 1'b0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, irq_level;
    wire [31:0] s_axi_rdata;
    wire sck_in, sck_out, sck_oe, sdi_in, sdo_out, sdo_oe, serial_irq_line;
    int failures = 0;
    int checks_done = 0;
    int seed = 32'hA3DB9860;
    logic [31:0] r;
    sssio_top #(.DIV0(4), .DIV1(6), .DIV2(8)) i_sssio_top (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .sleep_mode(sleep_mode),
        .stop_mode(stop_mode),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .sck_in(sck_in),
        .sck_out(sck_out),
        .sck_oe(sck_oe),
        .sdi_in(sdi_in),
        .sdo_out(sdo_out),
        .sdo_oe(sdo_oe),
        .serial_irq_line(serial_irq_line),
        .irq_level(irq_level)
    );
    sssio_peer i_sssio_peer (
        .sck_out(sck_out),
        .sck_oe(sck_oe),
        .sdo_out(sdo_out),
        .sck_in(sck_in),
        .sdi_in(sdi_in)
    );
    initial begin
        forever #20 aclk = ~aclk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
        int t = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && ++t < 100);
        // A response that never comes counts against the run
        if (s_axi_bvalid !== 1'b1) failures++;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        int t = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1 && ++t < 100);
        if (s_axi_rvalid !== 1'b1) failures++;
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rc(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
    endtask
    function automatic logic [7:0] expect_rx(input logic [7:0] v, input logic same);
        logic [7:0] b;
        for (int i = 0; i < 8; i++) b[i] = v[7 - i];
        return same ? v : b;
    endfunction
    task automatic xfer(input logic [1:0] cks, input logic [7:0] mine, input logic [7:0] theirs,
            input logic msb, input logic pmsb);
        logic [7:0] cfg;
        logic [31:0] d;
        int t = 0;
        cfg = {2'b00, cks != 2'h3, 1'b1, cks, msb, 1'b1};
        i_sssio_peer.load(theirs, pmsb);
        wr(4'h4, mine, 4'h1);
        wr(4'h0, cfg, 4'h1);
        if (cks == 2'h3) begin
            i_sssio_peer.frame(8);
            @(posedge aclk);
        end
        do rd(4'h0, d); while (d[0] === 1'b1 && ++t < 60);
        chk(d, {24'h0, 1'b1, cfg[6:1], 1'b0});
        chk(sck_oe, {31'h0, cks != 2'h3});
        chk(sdo_oe, 32'h1);
        rc(4'h4, {24'h0, expect_rx(theirs, msb == pmsb)});
        chk(i_sssio_peer.rx, {24'h0, expect_rx(mine, msb == pmsb)});
        chk(serial_irq_line, 32'h0);
        wr(4'h0, {2'b11, cfg[5:1], 1'b0}, 4'h1);
        chk(serial_irq_line, 32'h1);
        wr(4'h0, {2'b01, cfg[5:1], 1'b0}, 4'h1);
        chk(serial_irq_line, 32'h0);
        rc(4'h0, {24'h0, 2'b01, cfg[5:1], 1'b0});
    endtask
    task automatic summarize;
        $display("checks %0d, mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        summarize();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rc(4'h0, 32'h0);
        rc(4'h4, 32'h0);
        rc(4'h8, 32'hFF);
        chk(irq_level, 32'h3);
        wr(4'h8, 8'h04, 4'h1);
        chk(irq_level, 32'h1);
        wr(4'hC, 8'h0F, 4'h1);
        rc(4'hC, 32'h0);
        // Disabled strobe must leave the byte untouched
        wr(4'h4, 8'hA5, 4'h0);
        rc(4'h4, 32'h0);
        clk_en <= 1'b0;
        repeat (5) @(posedge aclk);
        clk_en <= 1'b1;
        @(posedge aclk);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            r = $random(seed);
            sleep_mode <= r[8];
            xfer(i[1:0], r[7:0], r[23:16], r[9], r[10]);
            $display("test transfer %0d done", i);
        end
        i_sssio_peer.load(8'h3C, 1'b0);
        wr(4'h4, 8'h3C, 4'h1);
        wr(4'h0, 8'h1D, 4'h1);
        i_sssio_peer.frame(3);
        @(posedge aclk);
        rc(4'hC, 32'h3);
        stop_mode <= 1'b1;
        i_sssio_peer.frame(2);
        @(posedge aclk);
        rc(4'hC, 32'h13);
        stop_mode <= 1'b0;
        wr(4'h0, 8'h1C, 4'h1);
        rc(4'hC, 32'h0);
        rc(4'h0, 32'h1C);
        wr(4'h4, 8'h01, 4'h1);
        i_sssio_peer.frame(1);
        @(posedge aclk);
        chk(sdo_out, 32'h1);
        wr(4'h4, 8'hFE, 4'h1);
        i_sssio_peer.frame(1);
        @(posedge aclk);
        chk(sdo_out, 32'h0);
        $display("test halt done");
        summarize();
    end
endmodule
`default_nettype wire
